// ==== shared/ess_defs.svh ====
// Offsets, reset values and field layout constants for the store sequencer.
// Assumes byte-wide registers at their own byte offsets on a plain register port.
`ifndef ESS_DEFS_SVH
`define ESS_DEFS_SVH
`define ESS_OFS_ANALOG1_INSTR   16'h0E34
`define ESS_OFS_ANALOG1_ADDR_HI 16'h0E35
`define ESS_OFS_ANALOG1_ADDR_LO 16'h0E36
`define ESS_OFS_DIGITAL1_INSTR  16'h0E37
`define ESS_OFS_DIGITAL1_ADDR_HI 16'h0E38
`define ESS_OFS_DIGITAL1_ADDR_LO 16'h0E39
`define ESS_OFS_DIGITAL2_INSTR  16'h0E3A
`define ESS_OFS_DIGITAL2_ADDR_HI 16'h0E3B
`define ESS_OFS_DIGITAL2_ADDR_LO 16'h0E3C
`define ESS_OFS_ANALOG2_INSTR   16'h0E3D
`define ESS_OFS_ANALOG2_ADDR_HI 16'h0E3E
`define ESS_OFS_ANALOG2_ADDR_LO 16'h0E3F
`define ESS_OFS_CTRL            16'h0EF0
`define ESS_OFS_STATUS          16'h0EF1
`define ESS_OFS_PTR_HI          16'h0EF2
`define ESS_OFS_PTR_LO          16'h0EF3
`define ESS_RST_ANALOG1_INSTR   8'h0E
`define ESS_RST_ANALOG1_ADDR    16'h0530
`define ESS_RST_DIGITAL1_INSTR  8'h33
`define ESS_RST_DIGITAL1_ADDR   16'h0540
`define ESS_RST_DIGITAL2_INSTR  8'h1E
`define ESS_RST_DIGITAL2_ADDR   16'h0600
`define ESS_RST_ANALOG2_INSTR   8'h0E
`define ESS_RST_ANALOG2_ADDR    16'h0630
`define ESS_CTRL_START_BIT      0
`define ESS_STAT_BUSY_BIT       0
`define ESS_STAT_DONE_BIT       1
`endif

// ==== shared/ess_pkg.sv ====
// Types shared by the store sequencer and its sequence table.
// Assumes the constants header is included by the files that need numbers.
package ess_pkg;
   typedef enum logic [2:0] {
      ESS_IDLE,
      ESS_INSTR,
      ESS_ADDR_HI,
      ESS_ADDR_LO,
      ESS_MAP_REQ,
      ESS_DATA,
      ESS_DONE
   } ess_state_e;

   // One byte heading for the EEPROM, with its EEPROM address.
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  data;
   } ess_wr_s;

   // One sequence entry: instruction byte and register-map start address.
   typedef struct packed {
      logic [7:0]  instr;
      logic [15:0] start;
   } ess_entry_s;
endpackage

// ==== design/ess_seq_table.sv ====
// Sequence table holding the four store entries, with registered read data.
// Assumes writes and reads come from the same clock domain as the sequencer.
`timescale 1ns/1ps
`include "ess_defs.svh"
module ess_seq_table
(
   input  wire logic                clk_in,
   input  wire logic                sys_rst_in,
   input  wire logic                ce_in,
   input  wire logic                wr_in,
   input  wire logic [3:0]          wr_idx_in,
   input  wire logic [7:0]          wr_data_in,
   input  wire logic [3:0]          rd_idx_in,
   output      logic [7:0]          rd_data_out,
   input  wire logic [1:0]          ent_idx_in,
   output      ess_pkg::ess_entry_s ent_out
);
   import ess_pkg::*;

   logic [7:0] mem [0:11];

   // Entry bytes; the high start-address byte sits at the lower offset.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         mem[0]  <= `ESS_RST_ANALOG1_INSTR;
         mem[1]  <= 8'(`ESS_RST_ANALOG1_ADDR >> 8);
         mem[2]  <= 8'(`ESS_RST_ANALOG1_ADDR & 16'h00FF);
         mem[3]  <= `ESS_RST_DIGITAL1_INSTR;
         mem[4]  <= 8'(`ESS_RST_DIGITAL1_ADDR >> 8);
         mem[5]  <= 8'(`ESS_RST_DIGITAL1_ADDR & 16'h00FF);
         mem[6]  <= `ESS_RST_DIGITAL2_INSTR;
         mem[7]  <= 8'(`ESS_RST_DIGITAL2_ADDR >> 8);
         mem[8]  <= 8'(`ESS_RST_DIGITAL2_ADDR & 16'h00FF);
         mem[9]  <= `ESS_RST_ANALOG2_INSTR;
         mem[10] <= 8'(`ESS_RST_ANALOG2_ADDR >> 8);
         mem[11] <= 8'(`ESS_RST_ANALOG2_ADDR & 16'h00FF);
      end
      else if (ce_in && wr_in && wr_idx_in < 4'hC)
      begin
         mem[wr_idx_in] <= wr_data_in;
      end
   end

   // Registered read port for software.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         rd_data_out <= 8'h00;
      end
      else if (ce_in)
      begin
         rd_data_out <= (rd_idx_in < 4'hC) ? mem[rd_idx_in] : 8'h00;
      end
   end

   // Registered entry port for the sequencer, high address byte first.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         ent_out <= '0;
      end
      else if (ce_in)
      begin
         ent_out <= {mem[{ent_idx_in, 2'b00} - {2'b00, ent_idx_in}],
                     mem[{ent_idx_in, 2'b00} - {2'b00, ent_idx_in} + 4'h1],
                     mem[{ent_idx_in, 2'b00} - {2'b00, ent_idx_in} + 4'h2]};
      end
   end
endmodule

// ==== design/ess_store_seq.sv ====
// Store sequencer: walks the store entries and writes each one to the EEPROM.
// Assumes an EEPROM writer that takes one byte per cycle while ready, and a
// register map that answers a read one cycle after the request.
// Each data byte costs a request cycle, the map read cycle, a cycle to catch
// the map answer and the offer itself, so a store moves about one byte per
// four cycles with a ready writer.
// Writes to the entry bytes are refused while a store runs, so an entry
// cannot change under the sequencer halfway through.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "ess_defs.svh"
module ess_store_seq
(
   input  wire logic             clk_in,
   input  wire logic             sys_rst_in,
   input  wire logic             ce_in,
   input  wire logic [15:0]      reg_addr_in,
   input  wire logic [7:0]       reg_wdata_in,
   input  wire logic             reg_wr_in,
   input  wire logic             reg_rd_in,
   output      logic [7:0]       reg_rdata_out,
   output      logic             map_rd_out,
   output      logic [15:0]      map_addr_out,
   input  wire logic [7:0]       map_data_in,
   output      logic             ee_valid_out,
   output      ess_pkg::ess_wr_s ee_wr_out,
   input  wire logic             ee_ready_in,
   output      logic             busy_out
);
   import ess_pkg::*;

   ess_state_e  state;
   ess_entry_s  ent;
   logic [1:0]  ent_idx;
   logic [15:0] ee_ptr;
   logic [8:0]  left;
   logic [15:0] map_ptr;
   logic        done;
   logic        map_pend;
   logic        tbl_wr;
   logic [3:0]  tbl_widx;
   logic [3:0]  tbl_ridx;
   logic [7:0]  tbl_rdata;
   logic        rd_tbl;
   logic [7:0]  rd_other;
   logic        ee_take;
   // Table fetch index, one edge ahead of ent_idx.
   logic [1:0]  next_ent_idx;
   // Start command decoded once for every process that acts on it.
   logic        start_req;

   // Byte count of a data instruction.
   function automatic logic [8:0] byte_count(input logic [7:0] instr);
      byte_count = {1'b0, instr} + 9'h001;
   endfunction

   // Table index for an offset in the entry window, or 0xF when outside it.
   function automatic logic [3:0] table_index(input logic [15:0] ofs);
      if (ofs >= `ESS_OFS_ANALOG1_INSTR && ofs <= `ESS_OFS_ANALOG2_ADDR_LO)
         table_index = 4'(ofs - `ESS_OFS_ANALOG1_INSTR);
      else
         table_index = 4'hF;
   endfunction

   // True for a register write that sets the start bit in the control register.
   function automatic logic start_cmd(input logic        wr,
                                      input logic [15:0] ofs,
                                      input logic [7:0]  wdata);
      start_cmd = wr && ofs == `ESS_OFS_CTRL && wdata[`ESS_CTRL_START_BIT];
   endfunction

   ess_seq_table u_table
   (
      .clk_in      (clk_in),
      .sys_rst_in  (sys_rst_in),
      .ce_in       (ce_in),
      .wr_in       (tbl_wr),
      .wr_idx_in   (tbl_widx),
      .wr_data_in  (reg_wdata_in),
      .rd_idx_in   (tbl_ridx),
      .rd_data_out (tbl_rdata),
      .ent_idx_in  (next_ent_idx),
      .ent_out     (ent)
   );

   // Table access decode; entries are locked while a store runs.
   assign tbl_widx = table_index(reg_addr_in);
   assign tbl_ridx = table_index(reg_addr_in);
   assign tbl_wr   = reg_wr_in && !busy_out && tbl_widx != 4'hF;
   assign busy_out = state != ESS_IDLE;
   assign ee_take  = ee_valid_out && ee_ready_in;
   assign start_req = state == ESS_IDLE && start_cmd(reg_wr_in, reg_addr_in, reg_wdata_in);

   // Entry index that the table fetches for the next cycle: it must lead the
   // state machine by one edge, or the first byte of an entry would come from
   // the entry before it.
   always_comb
   begin
      next_ent_idx = ent_idx;
      if (state == ESS_IDLE)
         next_ent_idx = 2'b00;
      else if (state == ESS_DATA && ee_take && left == 9'h001 && ent_idx != 2'b11)
         next_ent_idx = ent_idx + 2'b01;
   end

   // Marks a read that the sequence table answers in the following cycle.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         rd_tbl <= 1'b0;
      end
      else if (ce_in)
      begin
         rd_tbl <= reg_rd_in && tbl_ridx != 4'hF;
      end
   end

   // Read decode for the sequencer's own status registers.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         rd_other <= 8'h00;
      end
      else if (ce_in)
      begin
         if (!reg_rd_in)
            rd_other <= 8'h00;
         else if (reg_addr_in == `ESS_OFS_STATUS)
            rd_other <= {6'h00, done, busy_out};
         else if (reg_addr_in == `ESS_OFS_PTR_HI)
            rd_other <= ee_ptr[15:8];
         else if (reg_addr_in == `ESS_OFS_PTR_LO)
            rd_other <= ee_ptr[7:0];
         else
            rd_other <= 8'h00;
      end
   end

   // Outside the answer cycle the output shows rd_other, which is zero then.
   assign reg_rdata_out = rd_tbl ? tbl_rdata : rd_other;

   // Sequence state machine.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         state   <= ESS_IDLE;
         ent_idx <= 2'b00;
         left    <= 9'h000;
         map_ptr <= 16'h0000;
      end
      else if (ce_in)
      begin
         case (state)
            ESS_IDLE:
            begin
               // A start command always begins with the lowest entry.
               if (start_req)
               begin
                  ent_idx <= 2'b00;
                  state   <= ESS_INSTR;
               end
            end
            ESS_INSTR:
            begin
               // Count and start address are latched once the instruction is taken.
               if (ee_take)
               begin
                  left    <= byte_count(ent.instr);
                  map_ptr <= ent.start;
                  state   <= ESS_ADDR_HI;
               end
            end
            ESS_ADDR_HI:
            begin
               // High start-address byte goes out first.
               if (ee_take)
               begin
                  state <= ESS_ADDR_LO;
               end
            end
            ESS_ADDR_LO:
            begin
               // Low start-address byte, then the first map read.
               if (ee_take)
               begin
                  state <= ESS_MAP_REQ;
               end
            end
            ESS_MAP_REQ:
            begin
               // One cycle to issue the map read for the next data byte.
               state <= ESS_DATA;
            end
            ESS_DATA:
            begin
               // Every taken byte moves the map pointer on by one; the last byte
               // of an entry moves to the next entry, or ends the store.
               if (ee_take)
               begin
                  map_ptr <= map_ptr + 16'h0001;
                  left    <= left - 9'h001;
                  if (left != 9'h001)
                     state <= ESS_MAP_REQ;
                  else if (ent_idx == 2'b11)
                     state <= ESS_DONE;
                  else
                  begin
                     ent_idx <= ent_idx + 2'b01;
                     state   <= ESS_INSTR;
                  end
               end
            end
            ESS_DONE:
            begin
               // One cycle in done sets the flag, then back to idle.
               state <= ESS_IDLE;
            end
            default:
            begin
               // Unused codes fall back to idle.
               state <= ESS_IDLE;
            end
         endcase
      end
   end

   // Map read request, issued one cycle after the request state.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         map_rd_out   <= 1'b0;
         map_addr_out <= 16'h0000;
      end
      else if (ce_in)
      begin
         map_rd_out   <= state == ESS_MAP_REQ;
         map_addr_out <= map_ptr;
      end
   end

   // The map answers one cycle after the request, so its byte is only valid
   // in the cycle after map_rd_out; this flag marks that cycle.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         map_pend <= 1'b0;
      end
      else if (ce_in)
      begin
         map_pend <= map_rd_out;
      end
   end

   // EEPROM byte offer; each byte stands until the writer takes it.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         ee_valid_out <= 1'b0;
         ee_wr_out    <= '0;
      end
      else if (ce_in)
      begin
         // A taken byte drops the offer for one cycle before a header byte, three before a data byte.
         if (ee_take)
            ee_valid_out <= 1'b0;
         else if (!ee_valid_out && state == ESS_INSTR)
         begin
            ee_valid_out   <= 1'b1;
            ee_wr_out.data <= ent.instr;
            ee_wr_out.addr <= ee_ptr;
         end
         else if (!ee_valid_out && state == ESS_ADDR_HI)
         begin
            ee_valid_out   <= 1'b1;
            ee_wr_out.data <= ent.start[15:8];
            ee_wr_out.addr <= ee_ptr;
         end
         else if (!ee_valid_out && state == ESS_ADDR_LO)
         begin
            ee_valid_out   <= 1'b1;
            ee_wr_out.data <= ent.start[7:0];
            ee_wr_out.addr <= ee_ptr;
         end
         // A data byte is caught in the one cycle that the map answer stands.
         else if (!ee_valid_out && state == ESS_DATA && map_pend)
         begin
            ee_valid_out   <= 1'b1;
            ee_wr_out.data <= map_data_in;
            ee_wr_out.addr <= ee_ptr;
         end
      end
   end

   // EEPROM pointer: one step per byte written, reset by a start command.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         ee_ptr <= 16'h0000;
      end
      else if (ce_in)
      begin
         if (start_req)
            ee_ptr <= 16'h0000;
         else if (ee_take)
            ee_ptr <= ee_ptr + 16'h0001;
      end
   end

   // Done flag: set at the end of a store, cleared by the next start.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         done <= 1'b0;
      end
      else if (ce_in)
      begin
         if (state == ESS_DONE)
            done <= 1'b1;
         else if (start_req)
            done <= 1'b0;
      end
   end
endmodule

// ==== tb/ess_store_seq_monitor.sv ====
// Checker for the store sequencer, bound to its top module ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`include "ess_defs.svh"
module ess_store_seq_monitor
(
   input  wire logic             clk_in,
   input  wire logic             sys_rst_in,
   input  wire logic             ce_in,
   input  wire logic [15:0]      reg_addr_in,
   input  wire logic [7:0]       reg_wdata_in,
   input  wire logic             reg_wr_in,
   input  wire logic             reg_rd_in,
   input  wire logic [7:0]       reg_rdata_out,
   input  wire logic             map_rd_out,
   input  wire logic [15:0]      map_addr_out,
   input  wire logic [7:0]       map_data_in,
   input  wire logic             ee_valid_out,
   input  wire ess_pkg::ess_wr_s ee_wr_out,
   input  wire logic             ee_ready_in,
   input  wire logic             busy_out
);
   import ess_pkg::*;
   logic [15:0] n_take;
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // Counts bytes taken by the writer during one store.
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in || !busy_out) n_take <= 16'h0000;
      else if (ee_valid_out && ee_ready_in && ce_in) n_take <= n_take + 16'h0001;
   end
   // Each offered byte sits at the pointer, one past the last taken byte.
   a_ptr_step: assert property (ee_valid_out && ee_ready_in |-> ee_wr_out.addr == n_take)
      else $error("EEPROM address does not follow the byte count");
   a_offer_hold: assert property (ee_valid_out && !ee_ready_in |=> ee_valid_out && $stable(ee_wr_out))
      else $error("Offered byte changed before it was taken");
   a_map_to_ee: assert property (map_rd_out |-> ##2 (ee_valid_out && ee_wr_out.data == $past(map_data_in)))
      else $error("Map byte not passed on to the EEPROM");
   a_map_pulse: assert property (map_rd_out |=> !map_rd_out)
      else $error("Map read request longer than one cycle");
   a_unmapped_zero: assert property (reg_rd_in && reg_addr_in == 16'h0100 |=> reg_rdata_out == 8'h00)
      else $error("Unmapped read returned data");
   a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
      else $error("Read data outside the answer cycle");
   a_start_busy: assert property (reg_wr_in && ce_in && reg_addr_in == `ESS_OFS_CTRL && reg_wdata_in[0]
      && !busy_out |-> ##[1:2] busy_out)
      else $error("Start did not begin a store");
   a_idle_quiet: assert property (!busy_out && !$past(busy_out) |-> !map_rd_out)
      else $error("Map read while idle");
   c_stall: cover property (ee_valid_out && !ee_ready_in);
   c_take: cover property (ee_valid_out && ee_ready_in);
   c_busy_end: cover property ($fell(busy_out));
endmodule

// ==== tb/ess_ee_model.sv ====
// EEPROM writer and register map model facing the store sequencer.
// Assumes the map answers one cycle after a read and the writer may stall.
`timescale 1ns/1ps
module ess_ee_model
(
   input  wire logic             clk_in,
   input  wire logic             slow_in,
   input  wire logic             map_rd_in,
   input  wire logic [15:0]      map_addr_in,
   output      logic [7:0]       map_data_out,
   input  wire logic             ee_valid_in,
   input  wire ess_pkg::ess_wr_s ee_wr_in,
   output      logic             ee_ready_out
);
   import ess_pkg::*;
   logic [7:0] log_mem [256];
   int         n_taken = 0;
   logic [1:0] ph = 2'b00;
   // Stalls three cycles of four when slow, so the offer must be held.
   assign ee_ready_out = !slow_in || (ph == 2'b11);
   initial map_data_out = 8'h00;
   // Map answers a read next cycle, otherwise shows changing garbage.
   always @(posedge clk_in)
   begin
      ph <= ph + 2'b01;
      map_data_out <= map_rd_in ? (map_addr_in[7:0] ^ map_addr_in[15:8] ^ 8'h5A) : ~map_data_out;
      if (ee_valid_in && ee_ready_out)
      begin
         log_mem[ee_wr_in.addr[7:0]] <= ee_wr_in.data;
         n_taken <= n_taken + 1;
      end
   end
endmodule

// ==== tb/ess_store_seq_bench.sv ====
// Self-checking bench for the store sequencer with its far-side model.
// Assumes the model logs every EEPROM byte by its address.
`timescale 1ns/1ps
`include "ess_defs.svh"
module ess_store_seq_bench;
   import ess_pkg::*;
   logic clk_in, sys_rst_in, reg_wr, reg_rd, slow, map_rd, ee_valid, ee_ready, busy, ce;
   logic [15:0] reg_addr, map_addr;
   logic [7:0]  reg_wdata, rdata, map_data;
   ess_wr_s     ee_wr;
   int          n_mismatch = 0;
   int          checks = 0;
   logic [7:0]  tbl [12] = '{8'h0E, 8'h05, 8'h30, 8'h33, 8'h05, 8'h40,
                             8'h1E, 8'h06, 8'h00, 8'h0E, 8'h06, 8'h30};
   logic [7:0]  expq [$];
   ess_store_seq dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_rdata_out(rdata), .map_rd_out(map_rd), .map_addr_out(map_addr),
      .map_data_in(map_data), .ee_valid_out(ee_valid), .ee_wr_out(ee_wr),
      .ee_ready_in(ee_ready), .busy_out(busy));
   ess_ee_model ee_u (.clk_in(clk_in), .slow_in(slow), .map_rd_in(map_rd),
      .map_addr_in(map_addr), .map_data_out(map_data), .ee_valid_in(ee_valid),
      .ee_wr_in(ee_wr), .ee_ready_out(ee_ready));
   initial
   begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_in);
      reg_wr <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_in);
      reg_rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk_in);
   endtask
   // Runs one store, poking an entry while busy, then checks the stream.
   task automatic run_store(input int exp_n);
      int n0, i, k, t;
      logic [7:0] hi, lo;
      expq.delete();
      for (i = 0; i < 4; i++)
      begin
         for (k = 0; k < 3; k++) expq.push_back(tbl[3*i+k]);
         for (k = 0; k <= int'(tbl[3*i]); k++)
            expq.push_back(8'({tbl[3*i+1], tbl[3*i+2]} + 16'(k)) ^ tbl[3*i+1] ^ 8'h5A);
      end
      chk(16'(expq.size()), 16'(exp_n));
      n0 = ee_u.n_taken;
      wr(`ESS_OFS_CTRL, 8'h01);
      wr(`ESS_OFS_ANALOG2_INSTR, 8'h05);
      t = 0;
      while (busy !== 1'b0 && t < 20000)
      begin
         @(posedge clk_in);
         t++;
      end
      if (t >= 20000)
      begin
         chk(16'h0001, 16'h0000);
         end_of_test();
      end
      chk(16'(ee_u.n_taken - n0), 16'(exp_n));
      for (i = 0; i < exp_n; i++) chk(16'(ee_u.log_mem[i]), 16'(expq[i]));
      rd(`ESS_OFS_PTR_HI, hi);
      rd(`ESS_OFS_PTR_LO, lo);
      chk({hi, lo}, 16'(exp_n));
      rd(`ESS_OFS_STATUS, hi);
      chk(16'(hi), 16'h0002);
   endtask
   // Holds the clock enable low across a table write, which must not land.
   task automatic frozen_write;
      logic [7:0] d;
      ce <= 1'b0;
      wr(`ESS_OFS_ANALOG1_INSTR, 8'hAA);
      ce <= 1'b1;
      rd(`ESS_OFS_ANALOG1_INSTR, d);
      chk(16'(d), 16'(tbl[0]));
   endtask
   // Checks entry reset values, an unmapped and a write-only read.
   task automatic reset_values;
      logic [7:0] d;
      for (int i = 0; i < 12; i++)
      begin
         rd(`ESS_OFS_ANALOG1_INSTR + 16'(i), d);
         chk(16'(d), 16'(tbl[i]));
      end
      rd(16'h0100, d);
      chk(16'(d), 16'h0000);
      rd(`ESS_OFS_CTRL, d);
      chk(16'(d), 16'h0000);
   endtask
   // Shrinks entry one to one byte at a new start address, with a stalling writer.
   task automatic short_entry;
      logic [7:0] d;
      wr(`ESS_OFS_ANALOG1_INSTR, 8'h00);
      wr(`ESS_OFS_ANALOG1_ADDR_HI, 8'h12);
      wr(`ESS_OFS_ANALOG1_ADDR_LO, 8'h34);
      rd(`ESS_OFS_ANALOG1_ADDR_HI, d);
      chk(16'(d), 16'h0012);
      tbl[0] = 8'h00;
      tbl[1] = 8'h12;
      tbl[2] = 8'h34;
      slow <= 1'b1;
      run_store(111);
   endtask
   initial
   begin
      sys_rst_in = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      slow = 1'b0;
      ce = 1'b1;
      repeat (6) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      reset_values();
      frozen_write();
      run_store(125);
      short_entry();
      end_of_test();
   end
endmodule
bind ess_store_seq ess_store_seq_monitor mon_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .ce_in(ce_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .map_rd_out(map_rd_out), .map_addr_out(map_addr_out), .map_data_in(map_data_in),
   .ee_valid_out(ee_valid_out), .ee_wr_out(ee_wr_out), .ee_ready_in(ee_ready_in),
   .busy_out(busy_out));
